// file: pkg/lech_pkg.sv
// Constants for the lane error counter hold configuration block
package lech_pkg;

  // ==========================================================
  // Structure
  localparam int LINKS    = 2;
  localparam int LANES    = 3;
  localparam int NTYPE    = 3;
  localparam int CNT_W    = 8;
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int IDX_W    = 14;
  localparam int EVT_W    = LINKS * LANES;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE  = 14'h300;
  localparam logic [IDX_W-1:0] IDX_SOFT_RST   = 14'h475;
  localparam logic [IDX_W-1:0] IDX_HOLD_LANE2 = 14'h48a;
  localparam logic [IDX_W-1:0] IDX_HOLD_LANE3 = 14'h48b;
  localparam logic [IDX_W-1:0] IDX_HOLD_LANE4 = 14'h48c;
  localparam logic [IDX_W-1:0] IDX_CLEAR_BASE = 14'h4a2;
  localparam logic [IDX_W-1:0] IDX_COUNT_BASE = 14'h4b2;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS = 14'h4c0;
  localparam logic [IDX_W-1:0] IDX_INT_MASK   = 14'h4c1;

  // ==========================================================
  // Field positions
  localparam int BIT_CTRL     = 2;
  localparam int BIT_CODE     = 1;
  localparam int BIT_DISP     = 0;
  localparam int PAGE_BIT     = 0;
  localparam int SOFT_RST_BIT = 3;
  localparam int HOLD_W       = 3;

  // ==========================================================
  // Reset values and constants
  localparam logic [HOLD_W-1:0] HOLD_RESET     = 3'h7;
  localparam logic              SOFT_RST_RESET = 1'h0;
  localparam logic [EVT_W-1:0]  MASK_RESET     = 6'h00;
  localparam logic [CNT_W-1:0]  CNT_MAX        = 8'hff;
  localparam logic [1:0]        RESP_OKAY      = 2'h0;
  localparam logic [1:0]        RESP_SLVERR    = 2'h2;

endpackage

// file: design/lech_lane_cnt.sv
// Three error counters of one lane with hold or wrap at terminal count
`timescale 1ns/1ns
`default_nettype none

module lech_lane_cnt (
  // Clock and reset
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  // Control
  input  wire logic                                   enable,
  input  wire logic [lech_pkg::HOLD_W-1:0]            hold,
  input  wire logic [lech_pkg::HOLD_W-1:0]            clear,
  // Error events, bit 2 control char, 1 code, 0 disparity
  input  wire logic [lech_pkg::NTYPE-1:0]             error,
  // Results
  output logic [lech_pkg::NTYPE*lech_pkg::CNT_W-1:0]  count,
  output logic [lech_pkg::NTYPE-1:0]                  hit
);

  // ==========================================================
  // One counter per error type
  for (genvar t = 0; t < lech_pkg::NTYPE; t++) begin : g_type
    logic [lech_pkg::CNT_W-1:0] cnt;
    logic                       top;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt <= 8'h00;
        top <= 1'b0;
      end else begin
        top <= 1'b0;
        if (clear[t]) begin
          // Error in the clearing cycle still counts
          cnt <= (enable && error[t]) ? 8'h01 : 8'h00;
        end else if (enable && error[t]) begin
          if (cnt == lech_pkg::CNT_MAX && hold[t]) begin
            cnt <= cnt;
          end else begin
            cnt <= cnt + 8'h01;
          end
          if (cnt == lech_pkg::CNT_MAX - 8'h01) begin
            top <= 1'b1;
          end
        end
      end
    end

    assign count[t*lech_pkg::CNT_W +: lech_pkg::CNT_W] = cnt;
    assign hit[t] = top;
  end

endmodule

`default_nettype wire

// file: design/lech_axil_slave.sv
// AXI4-Lite slave front end with a simple register strobe port
`timescale 1ns/1ns
`default_nettype none

module lech_axil_slave (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Write address and data
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [lech_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [lech_pkg::DATA_W-1:0]   wdata,
  input  wire logic [3:0]                    wstrb,
  // Write response
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic [1:0]                         bresp,
  // Read address and data
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [lech_pkg::ADDR_W-1:0]   araddr,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic [lech_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                         rresp,
  // Register side
  output logic                               wr_en,
  output logic [lech_pkg::ADDR_W-1:0]        wr_addr,
  output logic [lech_pkg::DATA_W-1:0]        wr_data,
  output logic [3:0]                         wr_strb,
  input  wire logic                          wr_ok,
  output logic [lech_pkg::ADDR_W-1:0]        rd_addr,
  input  wire logic [lech_pkg::DATA_W-1:0]   rd_data,
  input  wire logic                          rd_ok
);

  logic aw_full;
  logic w_full;

  assign wr_en   = aw_full && w_full && !bvalid;
  assign rd_addr = araddr;

  // ==========================================================
  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      awready <= 1'b1;
      wr_addr <= 16'h0000;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else if (wr_en) begin
      aw_full <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  // ==========================================================
  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full  <= 1'b0;
      wready  <= 1'b1;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_full  <= 1'b1;
      wready  <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_full <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // ==========================================================
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= lech_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? lech_pkg::RESP_OKAY : lech_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= lech_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= rd_ok ? lech_pkg::RESP_OKAY : lech_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: design/lech_top.sv
// Paged lane error counter hold configuration with its error counters
//
// Notes on behaviour
// - Hold set: counter stays at 0xff until cleared
// - Hold clear: counter wraps to zero after 0xff
// - Field bit 2 control char, 1 code, 0 disparity
// - Link page register selects the accessed copy
// - Lanes 2, 3, 4 hold fields at 0x48a-0x48c
// - Bits 7:3 read zero; hold resets to 0x7
// - Per lane clear field, same bit mapping
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module lech_top (
  // Clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // AXI4-Lite write address
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [lech_pkg::ADDR_W-1:0]          awaddr,
  // AXI4-Lite write data
  input  wire logic                                 wvalid,
  output logic                                      wready,
  input  wire logic [lech_pkg::DATA_W-1:0]          wdata,
  input  wire logic [3:0]                           wstrb,
  // AXI4-Lite write response
  output logic                                      bvalid,
  input  wire logic                                 bready,
  output logic [1:0]                                bresp,
  // AXI4-Lite read address
  input  wire logic                                 arvalid,
  output logic                                      arready,
  input  wire logic [lech_pkg::ADDR_W-1:0]          araddr,
  // AXI4-Lite read data
  output logic                                      rvalid,
  input  wire logic                                 rready,
  output logic [lech_pkg::DATA_W-1:0]               rdata,
  output logic [1:0]                                rresp,
  // Lane error events, bit link*3 + lane-2
  input  wire logic [lech_pkg::EVT_W-1:0]           unexpected_control_char_error,
  input  wire logic [lech_pkg::EVT_W-1:0]           invalid_code_error,
  input  wire logic [lech_pkg::EVT_W-1:0]           disparity_error,
  // Control and interrupt
  output logic                                      deser_soft_reset,
  output logic                                      irq
);

  // ==========================================================
  // Declarations
  localparam int HW = lech_pkg::HOLD_W;
  localparam int NL = lech_pkg::LANES;
  localparam int NK = lech_pkg::LINKS;
  localparam int CW = lech_pkg::NTYPE * lech_pkg::CNT_W;

  logic                              wr_en;
  logic [lech_pkg::ADDR_W-1:0]       wr_addr;
  logic [lech_pkg::DATA_W-1:0]       wr_data;
  logic [3:0]                        wr_strb;
  logic                              wr_ok;
  logic [lech_pkg::ADDR_W-1:0]       rd_addr;
  logic [lech_pkg::DATA_W-1:0]       rd_data;
  logic                              rd_ok;

  logic [lech_pkg::IDX_W-1:0]        wr_idx;
  logic [lech_pkg::IDX_W-1:0]        rd_idx;
  logic [lech_pkg::IDX_W-1:0]        wr_hold_off;
  logic [lech_pkg::IDX_W-1:0]        wr_clr_off;
  logic [lech_pkg::IDX_W-1:0]        rd_hold_off;
  logic [lech_pkg::IDX_W-1:0]        rd_clr_off;
  logic [lech_pkg::IDX_W-1:0]        rd_cnt_off;
  logic                              wr_lo;

  logic                              link_page;
  logic [HW-1:0]                     hold     [NK][NL];
  logic [HW-1:0]                     clr      [NK][NL];
  logic [CW-1:0]                     cnt      [NK][NL];
  logic [lech_pkg::NTYPE-1:0]        hit      [NK][NL];
  logic [lech_pkg::EVT_W-1:0]        evt;
  logic [lech_pkg::EVT_W-1:0]        int_status;
  logic [lech_pkg::EVT_W-1:0]        int_mask;
  logic [lech_pkg::EVT_W-1:0]        next_status;

  // ==========================================================
  // Bus front end
  lech_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // ==========================================================
  // Address decode helpers
  assign wr_idx      = wr_addr[lech_pkg::ADDR_W-1:2];
  assign rd_idx      = rd_addr[lech_pkg::ADDR_W-1:2];
  assign wr_hold_off = wr_idx - lech_pkg::IDX_HOLD_LANE2;
  assign wr_clr_off  = wr_idx - lech_pkg::IDX_CLEAR_BASE;
  assign rd_hold_off = rd_idx - lech_pkg::IDX_HOLD_LANE2;
  assign rd_clr_off  = rd_idx - lech_pkg::IDX_CLEAR_BASE;
  assign rd_cnt_off  = rd_idx - lech_pkg::IDX_COUNT_BASE;
  assign wr_lo       = wr_en && wr_strb[0];

  // Writable map; count words accept and ignore writes
  always_comb begin
    if (wr_idx == lech_pkg::IDX_LINK_PAGE) begin
      wr_ok = 1'b1;
    end else if (wr_idx == lech_pkg::IDX_SOFT_RST) begin
      wr_ok = 1'b1;
    end else if (wr_hold_off < 14'(NL)) begin
      wr_ok = 1'b1;
    end else if (wr_clr_off < 14'(NL)) begin
      wr_ok = 1'b1;
    end else if (wr_idx - lech_pkg::IDX_COUNT_BASE < 14'(NL)) begin
      wr_ok = 1'b1;
    end else if (wr_idx == lech_pkg::IDX_INT_STATUS) begin
      wr_ok = 1'b1;
    end else if (wr_idx == lech_pkg::IDX_INT_MASK) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // ==========================================================
  // Link page selector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_page <= 1'b0;
    end else if (wr_lo && wr_idx == lech_pkg::IDX_LINK_PAGE) begin
      link_page <= wr_data[lech_pkg::PAGE_BIT];
    end
  end

  // ==========================================================
  // Deserializer soft reset, counting stops while it is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deser_soft_reset <= lech_pkg::SOFT_RST_RESET;
    end else if (wr_lo && wr_idx == lech_pkg::IDX_SOFT_RST) begin
      deser_soft_reset <= wr_data[lech_pkg::SOFT_RST_BIT];
    end
  end

  // ==========================================================
  // Hold enable fields, one copy per link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NK; k++) begin
        for (int l = 0; l < NL; l++) begin
          hold[k][l] <= lech_pkg::HOLD_RESET;
        end
      end
    end else if (wr_lo && wr_hold_off < 14'(NL)) begin
      // No guard on soft reset; software keeps to it
      hold[link_page][wr_hold_off[1:0]] <= wr_data[HW-1:0];
    end
  end

  // ==========================================================
  // Counter clear pulses, write one to clear
  always_comb begin
    for (int k = 0; k < NK; k++) begin
      for (int l = 0; l < NL; l++) begin
        clr[k][l] = '0;
        if (wr_lo && wr_clr_off == 14'(l) && link_page == k[0]) begin
          clr[k][l] = wr_data[HW-1:0];
        end
      end
    end
  end

  // ==========================================================
  // Counters, one instance per link and lane
  for (genvar k = 0; k < NK; k++) begin : g_link
    for (genvar l = 0; l < NL; l++) begin : g_lane
      localparam int E = k * NL + l;
      logic [lech_pkg::NTYPE-1:0] err;

      assign err[lech_pkg::BIT_CTRL] = unexpected_control_char_error[E];
      assign err[lech_pkg::BIT_CODE] = invalid_code_error[E];
      assign err[lech_pkg::BIT_DISP] = disparity_error[E];

      lech_lane_cnt u_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (!deser_soft_reset),
        .hold    (hold[k][l]),
        .clear   (clr[k][l]),
        .error   (err),
        .count   (cnt[k][l]),
        .hit     (hit[k][l])
      );

      assign evt[E] = |hit[k][l];
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  always_comb begin
    next_status = int_status;
    if (wr_lo && wr_idx == lech_pkg::IDX_INT_STATUS) begin
      next_status = next_status & ~wr_data[lech_pkg::EVT_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    next_status = next_status | evt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= '0;
    end else begin
      int_status <= next_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= lech_pkg::MASK_RESET;
    end else if (wr_lo && wr_idx == lech_pkg::IDX_INT_MASK) begin
      int_mask <= wr_data[lech_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

  // ==========================================================
  // Read mux, reserved bits read zero
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    if (rd_idx == lech_pkg::IDX_LINK_PAGE) begin
      rd_data[lech_pkg::PAGE_BIT] = link_page;
    end else if (rd_idx == lech_pkg::IDX_SOFT_RST) begin
      rd_data[lech_pkg::SOFT_RST_BIT] = deser_soft_reset;
    end else if (rd_hold_off < 14'(NL)) begin
      rd_data[HW-1:0] = hold[link_page][rd_hold_off[1:0]];
    end else if (rd_clr_off < 14'(NL)) begin
      rd_data = '0;
    end else if (rd_cnt_off < 14'(NL)) begin
      rd_data[CW-1:0] = cnt[link_page][rd_cnt_off[1:0]];
    end else if (rd_idx == lech_pkg::IDX_INT_STATUS) begin
      rd_data[lech_pkg::EVT_W-1:0] = int_status;
    end else if (rd_idx == lech_pkg::IDX_INT_MASK) begin
      rd_data[lech_pkg::EVT_W-1:0] = int_mask;
    end else begin
      rd_ok = 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: verification/lech_top_properties.sv
// Concurrent checks on the bus and control outputs of the top block
`timescale 1ns/1ns
`default_nettype none

module lech_checker (
  // Clock and reset
  input wire logic                        aclk,
  input wire logic                        aresetn,
  // Write channels
  input wire logic                        awvalid,
  input wire logic                        awready,
  input wire logic [lech_pkg::ADDR_W-1:0] awaddr,
  input wire logic                        wvalid,
  input wire logic                        wready,
  input wire logic [lech_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0]                  wstrb,
  input wire logic                        bvalid,
  input wire logic                        bready,
  input wire logic [1:0]                  bresp,
  // Read channels
  input wire logic                        arvalid,
  input wire logic                        arready,
  input wire logic                        rvalid,
  input wire logic                        rready,
  input wire logic [lech_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0]                  rresp,
  // Control
  input wire logic                        deser_soft_reset,
  input wire logic                        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Handshake sequences
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  sequence s_soft_wr;
    s_wr_taken ##0 (awaddr == {lech_pkg::IDX_SOFT_RST, 2'b00} && wstrb[0]);
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##1 !bvalid ##1 bvalid)
    else $error("write response not two cycles after take");
  a_read_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read data not one cycle after take");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_write_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_read_blocked: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  a_soft_reset_wr: assert property (s_soft_wr |->
    ##2 deser_soft_reset == $past(wdata[lech_pkg::SOFT_RST_BIT], 2))
    else $error("soft reset bit not taken from write");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    awready && arready && !bvalid && !rvalid && !irq && !deser_soft_reset)
    else $error("outputs not idle after reset");
endmodule

bind lech_top lech_checker u_chk (.aclk, .aresetn, .awvalid, .awready,
  .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
  .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .deser_soft_reset,
  .irq);

`default_nettype wire

// file: verification/lech_link_src.sv
// Lane error source standing in for the serial link transmitter
`timescale 1ns/1ns
`default_nettype none

module lech_link_src (
  // Clock
  input  wire logic                        aclk,
  // Error pulses
  output logic [lech_pkg::EVT_W-1:0]       unexpected_control_char_error,
  output logic [lech_pkg::EVT_W-1:0]       invalid_code_error,
  output logic [lech_pkg::EVT_W-1:0]       disparity_error
);
  initial begin
    unexpected_control_char_error = '0;
    invalid_code_error = '0;
    disparity_error = '0;
  end

  // One-cycle pulses, then 1 to 3 idle cycles
  task automatic send(input int b, input logic [2:0] t, input int n,
                      inout int s);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      unexpected_control_char_error[b] <= t[2];
      invalid_code_error[b] <= t[1];
      disparity_error[b] <= t[0];
      @(posedge aclk);
      unexpected_control_char_error <= '0;
      invalid_code_error <= '0;
      disparity_error <= '0;
      repeat ($unsigned($random(s)) % 3) @(posedge aclk);
    end
  endtask
endmodule

`default_nettype wire

// file: verification/lane_error_counter_hold_cfg_test.sv
// Self-checking bench for the lane error counter hold block
`timescale 1ns/1ns
`default_nettype none

module lane_error_counter_hold_cfg_test;
  typedef struct {
    logic [31:0] v;
    logic [1:0]  r;
    string       n;
  } lech_exp_t;

  logic                          aclk;
  logic                          aresetn;
  logic                          awvalid, wvalid, bready, arvalid, rready;
  logic                          awready, wready, bvalid, arready, rvalid;
  logic [15:0]                   awaddr, araddr;
  logic [31:0]                   wdata, rdata, hv[6];
  logic [3:0]                    wstrb;
  logic [1:0]                    bresp, rresp;
  logic                          deser_soft_reset, irq;
  logic [lech_pkg::EVT_W-1:0]    unexpected_control_char_error;
  logic [lech_pkg::EVT_W-1:0]    invalid_code_error;
  logic [lech_pkg::EVT_W-1:0]    disparity_error;
  lech_exp_t                     rq[$], bq[$];
  int                            miscompares, check_count, cycles, seed, n;

  lech_top u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp,
    .unexpected_control_char_error, .invalid_code_error, .disparity_error,
    .deser_soft_reset, .irq);
  lech_link_src u_src (.aclk, .unexpected_control_char_error,
    .invalid_code_error, .disparity_error);

  always #50 aclk = ~aclk;

  task automatic check(input string nm, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Result monitor and timeout
  always @(posedge aclk) begin
    lech_exp_t x;
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      x = rq.pop_front();
      check(x.n, x.v, rdata);
      check({x.n, " rresp"}, 32'(x.r), 32'(rresp));
    end
    if (bvalid === 1'b1 && bready && bq.size() > 0) begin
      x = bq.pop_front();
      check(x.n, 32'(x.r), 32'(bresp));
    end
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================================
  // Bus master tasks
  task automatic wr(input logic [13:0] i, input logic [31:0] d,
                    input logic [1:0] er);
    bit a, w, b;
    bq.push_back('{32'h0, er, "bresp"});
    awaddr <= {i, 2'b00};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (!a && awready) begin a = 1; awvalid <= 1'b0; end
      if (!w && wready) begin w = 1; wvalid <= 1'b0; end
      if (a && w && bvalid) begin b = 1; bready <= 1'b0; end
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [13:0] i, input logic [31:0] e,
                    input logic [1:0] er, input string nm);
    bit a, b;
    rq.push_back('{e, er, nm});
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (!a && arready) begin a = 1; arvalid <= 1'b0; end
      if (a && rvalid) begin b = 1; rready <= 1'b0; end
    end
    @(posedge aclk);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check("irq", 32'(e), 32'(irq));
    @(posedge aclk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    aclk = 0; aresetn = 0; seed = 18;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int p = 0; p < 2; p++) begin
      wr(14'h300, p, 2'h0);
      for (int l = 0; l < 3; l++)
        rd(14'(14'h48a + l), 32'h7, 2'h0, "hold reset");
    end
    wr(14'h475, 32'h8, 2'h0);
    check("soft reset", 32'h1, 32'(deser_soft_reset));
    for (int p = 0; p < 2; p++) begin
      wr(14'h300, p, 2'h0);
      for (int l = 0; l < 3; l++) begin
        hv[p*3+l] = $random(seed);
        wr(14'(14'h48a + l), hv[p*3+l], 2'h0);
      end
    end
    for (int p = 0; p < 2; p++) begin
      wr(14'h300, p, 2'h0);
      for (int l = 0; l < 3; l++)
        rd(14'(14'h48a + l), hv[p*3+l] & 32'h7, 2'h0, "hold");
    end
    wr(14'h300, 32'h0, 2'h0);
    wr(14'h48a, 32'h6, 2'h0);
    u_src.send(1, 3'b111, 3, seed);
    wr(14'h475, 32'h0, 2'h0);
    u_src.send(0, 3'b111, 257, seed);
    n = 1 + ($unsigned($random(seed)) % 20);
    u_src.send(4, 3'b111, n, seed);
    rd(14'h4b2, 32'h00ffff01, 2'h0, "count");
    wr(14'h300, 32'h1, 2'h0);
    rd(14'h4b3, {8'h0, {3{n[7:0]}}}, 2'h0, "count");
    rd(14'h4b2, 32'h0, 2'h0, "count");
    irq_is(1'b0);
    rd(14'h4c0, 32'h1, 2'h0, "status");
    wr(14'h4c1, 32'h1, 2'h0);
    irq_is(1'b1);
    wr(14'h4c1, 32'h0, 2'h0);
    irq_is(1'b0);
    wr(14'h4c1, 32'h1, 2'h0);
    wr(14'h4c0, 32'h1, 2'h0);
    irq_is(1'b0);
    rd(14'h4c0, 32'h0, 2'h0, "status");
    wr(14'h300, 32'h0, 2'h0);
    wr(14'h4a2, 32'h1, 2'h0);
    rd(14'h4b2, 32'h00ffff00, 2'h0, "count");
    wr(14'h4a2, 32'h6, 2'h0);
    wr(14'h4b2, 32'hff, 2'h0);
    rd(14'h4b2, 32'h0, 2'h0, "count");
    rd(14'h4b3, 32'h0, 2'h0, "count");
    rd(14'h3ff, 32'h0, 2'h2, "unmapped");
    wr(14'h3ff, 32'h1, 2'h2);
    repeat (2) @(posedge aclk);
    end_of_test();
  end
endmodule

`default_nettype wire
